// file: logic/pdsl_pkg.sv
// package: offsets, field layouts and reset values of the status and link capability registers
package pdsl_pkg;
  localparam logic [7:0] PDSL_OFF_DEV_STATUS = 8'hE8;
  localparam logic [7:0] PDSL_OFF_LINK_CAPS = 8'hEC;
  localparam logic [7:0] PDSL_OFF_IRQ_MASK = 8'hF8;
  localparam logic [7:0] PDSL_OFF_LOAD_CTRL = 8'hFC;
  localparam int PDSL_ERR_LSB = 16;
  localparam int PDSL_AUX_BIT = 20;
  localparam int PDSL_PEND_BIT = 21;
  localparam int PDSL_NUM_ERR = 4;
  localparam logic [3:0] PDSL_LINK_SPEED_2G5 = 4'h1;
  localparam logic [1:0] PDSL_ASPM_RST = 2'h1;
  localparam logic [2:0] PDSL_L0S_LAT_RST = 3'h3;
  localparam logic [2:0] PDSL_L1_LAT_RST = 3'h0;
  localparam logic [5:0] PDSL_WIDTH_RST = 6'h01;
  localparam int PDSL_NUM_PORTS = 3;
  localparam logic [1:0] PDSL_RESP_OKAY = 2'h0;
  localparam logic [1:0] PDSL_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {PDSL_PORT_UP, PDSL_PORT_DN} pdsl_port_kind_e;
endpackage : pdsl_pkg

// file: logic/pdsl_sync.sv
// three-flop synchroniser with agreement filter for a strap or event pin
`timescale 1ns/1ps
`default_nettype none
module pdsl_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pin in, filtered level out
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] lvl_r;
  wire [WIDTH-1:0] agree = ~(s2_r ^ s3_r);
  wire [WIDTH-1:0] lvl_nxt = (agree & s3_r) | (~agree & lvl_r);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
    end
    else
    begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end
  assign level = lvl_r;
endmodule : pdsl_sync
`default_nettype wire

// file: logic/pdsl_regs.sv
// status and link capability registers of one port, reached over axi4-lite
//
// Contract
// - a detected correctable error sets a sticky flag in bit 16, reset zero, cleared by writing one.
// - a detected non-fatal error sets a sticky flag in bit 17, reset zero, cleared by writing one.
// - a detected fatal error sets a sticky flag in bit 18, reset zero, cleared by writing one.
// - a detected unsupported request sets a sticky flag in bit 19, reset zero, cleared by writing one.
// - the four flags record errors regardless of the error reporting enables.
// - bit 20 is a read-only aux power detected indication that resets to one; the code resets it to zero, then follows the filtered aux_power_pin.
// - bit 21, transactions pending, always reads zero.
// - the maximum link speed field reads 0001b for a 2.5 Gb/s link.
// - the maximum link width comes from a strap pin or an eeprom preloaded value.
// - the read-only aspm support field resets to 01b.
// - the l0s exit latency field resets to 011b, 256 ns up to below 512 ns.
// - the l1 exit latency field resets to 000b, 16 us up to below 32 us.
// - surprise down reporting capable is zero on the upstream port and resets to zero; the code gives SURPRISE_DN_CAP on downstream ports, one from reset when set.
// - link active reporting capable is one on hot-plug downstream ports, zero upstream.
// - the port number resets to a distinct value for each port.
// - port number, aspm support and both exit latencies may be overridden by smbus or eeprom.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pdsl_regs
  import pdsl_pkg::*;
#(
  parameter pdsl_port_kind_e PORT_KIND = PDSL_PORT_UP,
  parameter logic [7:0] PORT_NUM = 8'h00,
  parameter logic HOTPLUG_CAP = 1'b0,
  parameter logic SURPRISE_DN_CAP = 1'b0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // error event pins: correctable, non-fatal, fatal, unsupported request
  input wire logic [PDSL_NUM_ERR-1:0] err_event_pin,
  // aux power sense pin and link width strap pins
  input wire logic aux_power_pin,
  input wire logic [5:0] link_width_strap,
  // side load from smbus or eeprom, one-cycle strobe with values
  input wire logic side_load_valid,
  input wire logic side_load_width_en,
  input wire logic [5:0] side_load_width,
  input wire logic [7:0] side_load_port_num,
  input wire logic [1:0] side_load_aspm,
  input wire logic [2:0] side_load_l0s,
  input wire logic [2:0] side_load_l1,
  // interrupt
  output logic irq
);
  logic [PDSL_NUM_ERR-1:0] err_lvl;
  logic [PDSL_NUM_ERR-1:0] err_prev_r;
  logic [PDSL_NUM_ERR-1:0] err_flag_r;
  logic [PDSL_NUM_ERR-1:0] err_flag_nxt;
  logic [PDSL_NUM_ERR-1:0] irq_mask_r;
  logic aux_lvl;
  logic [5:0] strap_lvl;
  logic strap_taken_r;
  logic [5:0] width_r;
  logic [7:0] port_num_r;
  logic [1:0] aspm_r;
  logic [2:0] l0s_r;
  logic [2:0] l1_r;
  logic width_from_eeprom_r;
  logic aw_full_r;
  logic w_full_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;

  // event pins arrive asynchronous, filtered before edge detection
  pdsl_sync #(.WIDTH(PDSL_NUM_ERR + 7)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin({err_event_pin, aux_power_pin, link_width_strap}),
    .level({err_lvl, aux_lvl, strap_lvl})
  );

  // write channel capture; both halves may come in either order
  wire aw_take = s_axi_awvalid && !aw_full_r && !bvalid_r;
  wire w_take = s_axi_wvalid && !w_full_r && !bvalid_r;
  wire wr_do = aw_full_r && w_full_r && !bvalid_r;
  wire wr_stat = wr_do && (awaddr_r[7:2] == PDSL_OFF_DEV_STATUS[7:2]);
  wire wr_mask = wr_do && (awaddr_r[7:2] == PDSL_OFF_IRQ_MASK[7:2]);
  wire wr_caps = wr_do && (awaddr_r[7:2] == PDSL_OFF_LINK_CAPS[7:2]);
  wire wr_load = wr_do && (awaddr_r[7:2] == PDSL_OFF_LOAD_CTRL[7:2]);
  wire wr_hit = wr_stat || wr_mask || wr_caps || wr_load;
  // byte lane 2 carries bits 23:16 where the flags sit
  wire [PDSL_NUM_ERR-1:0] w1c = (wr_stat && wstrb_r[2]) ?
    wdata_r[PDSL_ERR_LSB +: PDSL_NUM_ERR] : '0;
  wire [PDSL_NUM_ERR-1:0] err_rise = err_lvl & ~err_prev_r;

  // set wins over a simultaneous write-one clear; reporting enables are not consulted
  assign err_flag_nxt = (err_flag_r & ~w1c) | err_rise;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= PDSL_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_full_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_do)
      begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? PDSL_RESP_OKAY : PDSL_RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_full_r && !bvalid_r;
  assign s_axi_wready = !w_full_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      err_prev_r <= '0;
      err_flag_r <= '0;
      irq_mask_r <= '0;
    end
    else
    begin
      err_prev_r <= err_lvl;
      err_flag_r <= err_flag_nxt;
      if (wr_mask && wstrb_r[2])
        irq_mask_r <= wdata_r[PDSL_ERR_LSB +: PDSL_NUM_ERR];
    end
  end

  assign irq = |(err_flag_r & irq_mask_r);

  // capability defaults; software writes to the caps word are accepted and ignored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_num_r <= PORT_NUM;
      aspm_r <= PDSL_ASPM_RST;
      l0s_r <= PDSL_L0S_LAT_RST;
      l1_r <= PDSL_L1_LAT_RST;
      width_r <= PDSL_WIDTH_RST;
      width_from_eeprom_r <= 1'b0;
      strap_taken_r <= 1'b0;
    end
    else
    begin
      // strap level is copied every cycle without a side load, from one cycle after release until a side load with width enable
      strap_taken_r <= 1'b1;
      if (side_load_valid)
      begin
        port_num_r <= side_load_port_num;
        aspm_r <= side_load_aspm;
        l0s_r <= side_load_l0s;
        l1_r <= side_load_l1;
        if (side_load_width_en)
        begin
          width_r <= side_load_width;
          width_from_eeprom_r <= 1'b1;
        end
      end
      else if (!width_from_eeprom_r && strap_taken_r)
        width_r <= strap_lvl;
    end
  end

  wire surprise_cap = (PORT_KIND == PDSL_PORT_DN) && SURPRISE_DN_CAP;
  wire link_rep_cap = (PORT_KIND == PDSL_PORT_DN) && HOTPLUG_CAP;

  // status word: flags, aux level, pending tied low, rest zero
  wire [31:0] stat_word = {10'h000, 1'b0, aux_lvl, err_flag_r, 16'h0000};
  wire [31:0] caps_word = {port_num_r, 3'h0, link_rep_cap, surprise_cap, 1'b0, l1_r, l0s_r,
    aspm_r, width_r, PDSL_LINK_SPEED_2G5};
  wire [31:0] mask_word = {8'h00, 4'h0, irq_mask_r, 16'h0000};
  wire [31:0] load_word = {31'h0000_0000, width_from_eeprom_r};

  wire ar_take = s_axi_arvalid && !rvalid_r;
  wire rd_stat = s_axi_araddr[7:2] == PDSL_OFF_DEV_STATUS[7:2];
  wire rd_caps = s_axi_araddr[7:2] == PDSL_OFF_LINK_CAPS[7:2];
  wire rd_mask = s_axi_araddr[7:2] == PDSL_OFF_IRQ_MASK[7:2];
  wire rd_load = s_axi_araddr[7:2] == PDSL_OFF_LOAD_CTRL[7:2];
  wire rd_hit = rd_stat || rd_caps || rd_mask || rd_load;
  wire [31:0] rd_word = rd_stat ? stat_word :
                        rd_caps ? caps_word :
                        rd_mask ? mask_word :
                        rd_load ? load_word : 32'h0000_0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rresp_r <= PDSL_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end
    else if (ar_take)
    begin
      rvalid_r <= 1'b1;
      rresp_r <= rd_hit ? PDSL_RESP_OKAY : PDSL_RESP_SLVERR;
      rdata_r <= rd_word;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
endmodule : pdsl_regs
`default_nettype wire

// file: tb/pdsl_regs_props.sv
// checker: bus handshake and fixed-field properties of the register block
`timescale 1ns/1ps
`default_nettype none
module pdsl_regs_props
  import pdsl_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  input wire logic irq
);
  // address of the read in flight, so the answer can be judged by register
  logic [7:0] raddr_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      raddr_r <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready)
      raddr_r <= s_axi_araddr;
  end
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_waiting;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  // both halves are parked for one cycle before the response is raised
  a_write_answer: assert property (both_taken |=> ##1 s_axi_bvalid)
    else $error("no write response after both halves");
  a_b_hold: assert property (b_waiting |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  a_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data after address");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while waiting");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_irq_reset: assert property ($past(!aresetn) |-> !irq)
    else $error("interrupt high right after reset");
  a_unmap_zero: assert property (s_axi_rvalid && s_axi_rresp == PDSL_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
  a_stat_rsvd: assert property (s_axi_rvalid && raddr_r == PDSL_OFF_DEV_STATUS |-> s_axi_rdata[31:21] == 11'h0)
    else $error("status upper bits not zero");
  a_caps_fixed: assert property (s_axi_rvalid && raddr_r == PDSL_OFF_LINK_CAPS |->
    s_axi_rdata[3:0] == 4'h1 && !s_axi_rdata[18] && s_axi_rdata[23:21] == 3'h0)
    else $error("caps fixed fields wrong");
endmodule : pdsl_regs_props
`default_nettype wire

// file: tb/test_pdsl_regs.sv
// testbench: register reads and writes, error events, side load, unmapped space
`timescale 1ns/1ps
`default_nettype none
module test_pdsl_regs;
  import pdsl_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, side_load_port_num = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb = 4'hF, err_event_pin = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, aux_power_pin = 1'b1;
  logic side_load_valid = 1'b0, side_load_width_en = 1'b0;
  logic [5:0] link_width_strap = 6'h04, side_load_width = 6'h00;
  logic [1:0] side_load_aspm = 2'h0, s_axi_bresp, s_axi_rresp, resp;
  logic [2:0] side_load_l0s = 3'h0, side_load_l1 = 3'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  int mismatches = 0, n_checks = 0;
  // aux bit set, flags clear
  localparam logic [31:0] STAT_IDLE = 32'h00100000;
  always #5 aclk = ~aclk;
  pdsl_regs #(.PORT_KIND(PDSL_PORT_DN), .PORT_NUM(8'h02), .HOTPLUG_CAP(1'b1),
    .SURPRISE_DN_CAP(1'b1)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .err_event_pin,
    .aux_power_pin, .link_width_strap, .side_load_valid, .side_load_width_en,
    .side_load_width, .side_load_port_num, .side_load_aspm, .side_load_l0s,
    .side_load_l1, .irq);
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // handshakes are judged at the falling edge, where they already equal the next rising edge
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd, bd;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    while (!(ad && wd))
    begin
      @(negedge aclk);
      ad = ad || (s_axi_awvalid && s_axi_awready);
      wd = wd || (s_axi_wvalid && s_axi_wready);
      @(posedge aclk);
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b1;
    bd = 1'b0;
    while (!bd)
    begin
      @(negedge aclk);
      bd = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
    end
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(resp), 32'(er));
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er, input string n);
    logic ad;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    ad = 1'b0;
    while (!ad)
    begin
      @(negedge aclk);
      ad = s_axi_arready;
      @(posedge aclk);
    end
    s_axi_arvalid <= 1'b0;
    ad = 1'b0;
    while (!ad)
    begin
      @(negedge aclk);
      ad = s_axi_rvalid;
      rd_data = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
    end
    s_axi_rready <= 1'b0;
    chk(n, rd_data, ed);
    chk("rresp", 32'(resp), 32'(er));
  endtask : rd
  task results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
    rd(PDSL_OFF_DEV_STATUS, STAT_IDLE, PDSL_RESP_OKAY, "status");
    rd(PDSL_OFF_LINK_CAPS, {8'h02, 3'h0, 2'h3, 1'h0, 3'h0, 3'h3, 2'h1, 6'h04, 4'h1},
      PDSL_RESP_OKAY, "caps");
    // all-ones writes must leave read-only and reserved bits alone
    wr(PDSL_OFF_LINK_CAPS, 32'hFFFFFFFF, PDSL_RESP_OKAY);
    wr(PDSL_OFF_DEV_STATUS, 32'hFFFFFFFF, PDSL_RESP_OKAY);
    rd(PDSL_OFF_LINK_CAPS, {8'h02, 3'h0, 2'h3, 1'h0, 3'h0, 3'h3, 2'h1, 6'h04, 4'h1},
      PDSL_RESP_OKAY, "caps");
    rd(PDSL_OFF_DEV_STATUS, STAT_IDLE, PDSL_RESP_OKAY, "status");
    // correctable left masked, so that event must not reach irq
    wr(PDSL_OFF_IRQ_MASK, 32'h000E0000, PDSL_RESP_OKAY);
    for (int i = 0; i < 4; i++)
    begin
      err_event_pin[i] <= 1'b1;
      repeat (10) @(posedge aclk);
      chk("irq", 32'(irq), 32'(i != 0));
      rd(PDSL_OFF_DEV_STATUS, STAT_IDLE | (32'h1 << (16 + i)), PDSL_RESP_OKAY, "flag");
      err_event_pin[i] <= 1'b0;
      wr(PDSL_OFF_DEV_STATUS, 32'h1 << (16 + i), PDSL_RESP_OKAY);
      rd(PDSL_OFF_DEV_STATUS, STAT_IDLE, PDSL_RESP_OKAY, "flag");
      chk("irq", 32'(irq), 32'h0);
    end
    aux_power_pin <= 1'b0;
    repeat (10) @(posedge aclk);
    rd(PDSL_OFF_DEV_STATUS, 32'h0, PDSL_RESP_OKAY, "aux");
    side_load_port_num <= 8'h5A;
    side_load_aspm <= 2'h3;
    side_load_l0s <= 3'h5;
    side_load_l1 <= 3'h6;
    side_load_width <= 6'h08;
    side_load_width_en <= 1'b1;
    side_load_valid <= 1'b1;
    @(posedge aclk);
    side_load_valid <= 1'b0;
    rd(PDSL_OFF_LINK_CAPS, {8'h5A, 3'h0, 2'h3, 1'h0, 3'h6, 3'h5, 2'h3, 6'h08, 4'h1},
      PDSL_RESP_OKAY, "loaded");
    rd(8'h80, 32'h0, PDSL_RESP_SLVERR, "unmapped");
    wr(8'h80, 32'hFFFFFFFF, PDSL_RESP_SLVERR);
    results();
  end
  // whole run is under 150 cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    results();
  end
endmodule : test_pdsl_regs
bind pdsl_regs pdsl_regs_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .irq);
`default_nettype wire
